/* hdl/spcd_decoder.sv */
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module spcd_decoder
    import spcd_pkg::*;
#(
    parameter int FADE_CYCLES = FADE_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Serial command link
    input wire logic ser_clk,
    input wire logic ser_cs_n,
    input wire logic ser_di,
    output logic cmd_busy_n,
    output logic [3:0] channel_busy_n,
    // Decoded results
    output logic powered_up,
    output spcd_ana_t ana_eff,
    output spcd_cmd_t cmd_out,
    output logic cmd_valid,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    logic rx_valid;
    logic [7:0] rx_byte;
    logic dbl_mode_reg;
    logic half_reg;
    logic [7:0] first_reg;
    logic wcm_err_reg;
    logic [1:0] idx_reg;
    logic [7:0] b0_reg;
    logic [7:0] b1_reg;
    logic [7:0] proc_cnt_reg;
    spcd_ana_t ana_reg;
    spcd_ana_st_t ana_st_reg;
    logic [15:0] ramp_cnt_reg;
    logic [3:0] fading_reg;
    logic [31:0] fade_cnt_reg;
    logic eb_valid;
    logic mismatch;
    logic fin;
    logic drop;
    logic [7:0] c0;
    logic [7:0] c1;
    spcd_kind_t kind;
    logic playing;
    logic ana_skip;
    logic bus_req;
    logic bus_ack;
    logic [3:0] sw_done;
    logic [31:0] rdata;

    spcd_serial_rx u_rx (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ser_clk(ser_clk),
        .ser_cs_n(ser_cs_n),
        .ser_di(ser_di),
        .byte_valid(rx_valid),
        .byte_data(rx_byte)
    );

    // ********************
    // Double entry pairing
    // ********************
    assign eb_valid = rx_valid && (!dbl_mode_reg || half_reg) && !mismatch;
    assign mismatch = rx_valid && dbl_mode_reg && half_reg && (rx_byte != first_reg);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_reg <= 1'b0;
            first_reg <= 8'h00;
        end else if (rx_valid && dbl_mode_reg) begin
            half_reg <= !half_reg;
            first_reg <= rx_byte;
        end else if (!dbl_mode_reg) begin
            half_reg <= 1'b0;
        end
    end

    // Mismatch flag: set wins over the error-clear command
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wcm_err_reg <= 1'b0;
        end else if (mismatch) begin
            wcm_err_reg <= 1'b1;
        end else if (fin && kind == CK_ERRCL) begin
            wcm_err_reg <= 1'b0;
        end
    end

    // ********************
    // Command assembly
    // ********************
    assign c0 = (idx_reg == 2'd0) ? rx_byte : b0_reg;
    assign c1 = (idx_reg == 2'd1) ? rx_byte : b1_reg;
    assign kind = spcd_kind(c0);
    // Powered down: anything but power-up is dropped on the first byte
    assign drop = !powered_up && (idx_reg == 2'd0) && (spcd_kind(rx_byte) != CK_PUP);
    assign fin = eb_valid && !drop && (idx_reg == spcd_len(c0) - 2'd1);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_reg <= 2'd0;
            b0_reg <= 8'h00;
            b1_reg <= 8'h00;
        end else if (mismatch) begin
            idx_reg <= 2'd0;
        end else if (eb_valid && !drop) begin
            if (fin) begin
                idx_reg <= 2'd0;
            end else begin
                idx_reg <= idx_reg + 2'd1;
                if (idx_reg == 2'd0) b0_reg <= rx_byte;
                else b1_reg <= rx_byte;
            end
        end
    end

    // ********************
    // Power state
    // ********************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            powered_up <= 1'b0;
            dbl_mode_reg <= 1'b0;
        end else if (fin && kind == CK_PUP && !powered_up) begin
            powered_up <= 1'b1;
            dbl_mode_reg <= c0[0];
        end else if (fin && kind == CK_POWER_DOWN_CMD) begin
            powered_up <= 1'b0;
            dbl_mode_reg <= 1'b0;
        end
    end

    // ********************
    // Analog section
    // ********************
    assign playing = (channel_busy_n != 4'hf);
    // A refused setup is not an accepted command: no strobe, no update
    assign ana_skip = (kind == CK_ANA) && !(powered_up && !playing
                      && (ana_st_reg == ANA_OFF || ana_st_reg == ANA_ON));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ana_reg <= ANA_RST;
            ana_st_reg <= ANA_OFF;
            ramp_cnt_reg <= 16'h0000;
        end else if (fin && kind == CK_POWER_DOWN_CMD) begin
            // Drop at once; a ramp-up in flight gets no quiet ramp-down
            ana_reg <= ANA_RST;
            ana_st_reg <= ANA_OFF;
            ramp_cnt_reg <= 16'h0000;
        end else if (fin && kind == CK_ANA && !ana_skip) begin
            ana_reg <= {c1, c0[1:0]};
            ramp_cnt_reg <= 16'(ANA_RAMP_CYC);
            if (c1[2:1] != 2'b00) ana_st_reg <= ANA_UP;
            else if (ana_st_reg == ANA_ON) ana_st_reg <= ANA_DN;
            else ramp_cnt_reg <= 16'h0000;
        end else if (ramp_cnt_reg != 16'h0000) begin
            ramp_cnt_reg <= ramp_cnt_reg - 16'h0001;
            if (ramp_cnt_reg == 16'h0001) begin
                ana_st_reg <= (ana_st_reg == ANA_UP) ? ANA_ON : ANA_OFF;
            end
        end
    end

    // Gains and line output only count in class AB
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ana_eff <= ANA_RST;
        end else begin
            ana_eff.soft_stop_enable <= ana_reg.soft_stop_enable;
            ana_eff.class_d_select <= ana_reg.class_d_select;
            ana_eff.highpass_enable <= ana_reg.highpass_enable;
            ana_eff.dac_path_gain <= ana_reg.class_d_select ? 2'b00 : ana_reg.dac_path_gain;
            ana_eff.ext_input_gain <= ana_reg.class_d_select ? 2'b00 : ana_reg.ext_input_gain;
            ana_eff.line_amp_enable <= ana_reg.line_amp_enable && !ana_reg.class_d_select;
            ana_eff.speaker_amp_enable <= ana_reg.speaker_amp_enable;
            ana_eff.click_suppress <= ana_reg.click_suppress && ana_reg.line_amp_enable
                                      && !ana_reg.class_d_select;
        end
    end

    // ********************
    // Command busy
    // ********************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            proc_cnt_reg <= 8'h00;
        end else if (rx_valid) begin
            proc_cnt_reg <= 8'(CMD_PROC_CYC);
        end else if (proc_cnt_reg != 8'h00) begin
            proc_cnt_reg <= proc_cnt_reg - 8'h01;
        end
    end

    // Held low across analog ramps so the host waits before feeding input
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_busy_n <= 1'b1;
        end else begin
            cmd_busy_n <= !(rx_valid || proc_cnt_reg > 8'h01
                            || ramp_cnt_reg > 16'h0001);
        end
    end

    // ********************
    // Channel busy and fade
    // ********************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fading_reg <= 4'h0;
            fade_cnt_reg <= 32'h0;
        end else if (fin && kind == CK_STOP && ana_reg.soft_stop_enable) begin
            fading_reg <= fading_reg | (c0[3:0] & ~channel_busy_n);
            fade_cnt_reg <= 32'(FADE_CYCLES);
        end else if (fade_cnt_reg != 32'h0) begin
            fade_cnt_reg <= fade_cnt_reg - 32'h1;
        end else begin
            fading_reg <= 4'h0;
        end
    end

    // Start wins over a software release in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_busy_n <= 4'hf;
        end else if (fin && kind == CK_POWER_DOWN_CMD) begin
            channel_busy_n <= 4'hf;
        end else if (fin && kind == CK_START) begin
            channel_busy_n <= channel_busy_n & ~c0[3:0];
        end else if (fin && kind == CK_PLAY) begin
            channel_busy_n[c0[1:0]] <= 1'b0;
        end else if (fin && kind == CK_WPLAY) begin
            channel_busy_n[c1[5:4]] <= 1'b0;
        end else if (fin && kind == CK_STOP && !ana_reg.soft_stop_enable) begin
            channel_busy_n <= channel_busy_n | c0[3:0];
        end else if (fading_reg != 4'h0 && fade_cnt_reg == 32'h1) begin
            channel_busy_n <= channel_busy_n | fading_reg;
        end else begin
            channel_busy_n <= channel_busy_n | sw_done;
        end
    end

    // ********************
    // Decoded command out
    // ********************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid <= 1'b0;
            cmd_out <= '0;
        end else begin
            cmd_valid <= fin && !ana_skip;
            if (fin && !ana_skip) begin
                cmd_out.kind <= kind;
                cmd_out.channel_mask <= c0[3:0];
                cmd_out.channel_index <= (kind == CK_WPLAY) ? c1[5:4] : c0[1:0];
                if (kind == CK_WPLAY) cmd_out.phrase_number <= {c1[3:0], rx_byte};
                else cmd_out.phrase_number <= {2'b00, c0[3:2], c1};
            end
        end
    end

    // ********************
    // Avalon-MM slave
    // ********************
    assign bus_req = avs_read || avs_write;
    assign bus_ack = bus_req && !avs_waitrequest;
    assign sw_done = (bus_ack && avs_write && avs_address == REG_CTRL)
                     ? avs_writedata[3:0] : 4'h0;

    always_comb begin
        rdata = 32'h0;
        case (avs_address)
            REG_CTRL: rdata = 32'h0;
            REG_STATUS: rdata = {22'h0, wcm_err_reg, dbl_mode_reg, ana_st_reg,
                                 cmd_busy_n, powered_up, channel_busy_n};
            REG_ANALOG: rdata = {22'h0, ana_reg};
            REG_LASTCMD: rdata = {10'h0, cmd_out};
            default: rdata = 32'h0;
        endcase
    end

    // One wait cycle on every access
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            avs_waitrequest <= !(bus_req && avs_waitrequest);
            if (avs_read && avs_waitrequest) avs_readdata <= rdata;
        end
    end

endmodule

/* inc/spcd_pkg.sv */
// Functional notes
// - Commands are whole bytes; lengths one, two or three bytes by opcode.
// - Power-up command moves power-down state to command standby.
// - While powered down, every byte except power-up is ignored.
// - Double-entry mode: each byte sent twice, mismatched command discarded.
// - Analog setup ignored while down, ramping, or any channel playing.
// - Power-down during analog ramp-up drops immediately, no pop suppression.
// - Analog settings return to reset values on reset or power-down.
// - class_d_select: 0 selects class AB, 1 selects class D.
// - highpass_enable 1 inserts 200Hz high-pass filter, 0 bypasses it.
// - Soft stop fades out, channel_busy_n low until fade ends.
// - dac_path_gain 00 off, 01 -6dB, 10 0dB; class AB only.
// - ext_input_gain 00 off, 01 -6dB, 10 0dB; class AB only.
// - Analog setup decoded as two bytes with fixed field layout.
// - Start, stop, repeat set/clear by upper nibble; lower nibble channel mask.
// - Wide play: second byte 00, index, phrase 11..8; third phrase 7..0.
// - click_suppress ramps line output quietly; applies only to line output.
// - Enable pair: 00 down, low bit speaker, high bit line; no line with class D.
package spcd_pkg;

    // ********************
    // Timing
    // ********************
    localparam int CLK_PERIOD_NS = 8;
    localparam int CMD_PROC_NS = 128;
    localparam int CMD_PROC_CYC = (CMD_PROC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ANA_RAMP_NS = 10000;
    localparam int ANA_RAMP_CYC = (ANA_RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FADE_NS = 4000000;
    localparam int FADE_CYC = (FADE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ********************
    // Register map
    // ********************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_ANALOG = 4'h8;
    localparam logic [3:0] REG_LASTCMD = 4'hc;

    // ********************
    // Opcodes
    // ********************
    localparam logic [6:0] OP_PUP = 7'h00;
    localparam logic [5:0] OP_ANA = 6'h01;
    localparam logic [7:0] OP_POWER_DOWN_CMD = 8'h20;
    localparam logic [7:0] OP_WDTCL = 8'h14;
    localparam logic [7:0] OP_ERRCL = 8'hff;
    localparam logic [7:0] OP_FADR2 = 8'hc4;
    localparam logic [7:0] OP_WPLAY = 8'hc8;
    localparam logic [3:0] NB_PLAY = 4'h4;
    localparam logic [3:0] NB_START = 4'h5;
    localparam logic [3:0] NB_STOP = 4'h6;
    localparam logic [3:0] NB_RSET = 4'h8;
    localparam logic [3:0] NB_RCLR = 4'h9;

    typedef enum logic [3:0] {
        CK_OTHER = 4'h0,
        CK_PUP = 4'h1,
        CK_POWER_DOWN_CMD = 4'h2,
        CK_ANA = 4'h3,
        CK_PLAY = 4'h4,
        CK_WPLAY = 4'h5,
        CK_START = 4'h6,
        CK_STOP = 4'h7,
        CK_RSET = 4'h8,
        CK_RCLR = 4'h9,
        CK_ERRCL = 4'ha,
        CK_WDTCL = 4'hb
    } spcd_kind_t;

    typedef enum logic [1:0] {
        ANA_OFF = 2'b00,
        ANA_UP = 2'b01,
        ANA_ON = 2'b10,
        ANA_DN = 2'b11
    } spcd_ana_st_t;

    // Second byte of analog setup first, then the two bits of the first byte
    typedef struct packed {
        logic soft_stop_enable;
        logic [1:0] dac_path_gain;
        logic [1:0] ext_input_gain;
        logic line_amp_enable;
        logic speaker_amp_enable;
        logic click_suppress;
        logic class_d_select;
        logic highpass_enable;
    } spcd_ana_t;

    typedef struct packed {
        spcd_kind_t kind;
        logic [3:0] channel_mask;
        logic [1:0] channel_index;
        logic [11:0] phrase_number;
    } spcd_cmd_t;

    localparam spcd_ana_t ANA_RST = 10'h000;

    function automatic spcd_kind_t spcd_kind(input logic [7:0] b);
        spcd_kind_t k;
        k = CK_OTHER;
        if (b[7:1] == OP_PUP) k = CK_PUP;
        else if (b[7:2] == OP_ANA) k = CK_ANA;
        else if (b == OP_POWER_DOWN_CMD) k = CK_POWER_DOWN_CMD;
        else if (b == OP_WDTCL) k = CK_WDTCL;
        else if (b == OP_ERRCL) k = CK_ERRCL;
        else if (b == OP_WPLAY) k = CK_WPLAY;
        else if (b[7:4] == NB_PLAY) k = CK_PLAY;
        else if (b[7:4] == NB_START) k = CK_START;
        else if (b[7:4] == NB_STOP) k = CK_STOP;
        else if (b[7:4] == NB_RSET) k = CK_RSET;
        else if (b[7:4] == NB_RCLR) k = CK_RCLR;
        return k;
    endfunction

    function automatic logic [1:0] spcd_len(input logic [7:0] b);
        logic [1:0] n;
        n = 2'd2;
        if (b == OP_WPLAY || b == OP_FADR2) n = 2'd3;
        else if (b[7:1] == OP_PUP || b == OP_POWER_DOWN_CMD || b == OP_WDTCL || b == OP_ERRCL)
            n = 2'd1;
        else if (b[7:4] == NB_START || b[7:4] == NB_STOP) n = 2'd1;
        else if (b[7:4] == NB_RSET || b[7:4] == NB_RCLR) n = 2'd1;
        return n;
    endfunction

endpackage

/* hdl/spcd_serial_rx.sv */
`timescale 1ns/1ps
module spcd_serial_rx
    import spcd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Serial pins
    input wire logic ser_clk,
    input wire logic ser_cs_n,
    input wire logic ser_di,
    // Byte out
    output logic byte_valid,
    output logic [7:0] byte_data
);

    logic [2:0] s1_reg;
    logic [2:0] s2_reg;
    logic clk_d_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic rise;

    // ********************
    // Synchronisers
    // ********************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 3'h4;
            s2_reg <= 3'h4;
            clk_d_reg <= 1'b0;
        end else begin
            s1_reg <= {ser_cs_n, ser_clk, ser_di};
            s2_reg <= s1_reg;
            clk_d_reg <= s2_reg[1];
        end
    end

    assign rise = s2_reg[1] && !clk_d_reg && !s2_reg[2];

    // ********************
    // Shifter, MSB first
    // ********************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 7'h00;
            byte_valid <= 1'b0;
            byte_data <= 8'h00;
        end else begin
            byte_valid <= 1'b0;
            if (s2_reg[2]) begin
                // Deselect drops a partial byte
                bit_cnt_reg <= 3'h0;
            end else if (rise) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                shift_reg <= {shift_reg[5:0], s2_reg[0]};
                if (bit_cnt_reg == 3'h7) begin
                    byte_valid <= 1'b1;
                    byte_data <= {shift_reg, s2_reg[0]};
                end
            end
        end
    end

endmodule

/* verif/spcd_decoder_chk.sv */
`timescale 1ns/1ps
module spcd_decoder_chk
    import spcd_pkg::*;
#(
    parameter int FADE_CYCLES = 20
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Observed outputs
    input wire logic [3:0] channel_busy_n,
    input wire logic powered_up,
    input wire spcd_ana_t ana_eff,
    input wire spcd_cmd_t cmd_out,
    input wire logic cmd_valid
);
    // Slack over the fade count for decode and release latency
    localparam int FADE_MAX = FADE_CYCLES + 10;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_valid_pulse: assert property (cmd_valid |=> !cmd_valid)
        else $error("command strobe longer than one cycle");
    a_down_quiet: assert property (cmd_valid && cmd_out.kind != CK_PUP |-> $past(powered_up))
        else $error("command accepted while powered down");
    a_pup_wakes: assert property (cmd_valid && cmd_out.kind == CK_PUP |-> ##[0:2] powered_up)
        else $error("power-up command did not wake the device");
    a_power_down_cmd_clears: assert property (cmd_valid && cmd_out.kind == CK_POWER_DOWN_CMD
        |-> ##[0:2] (!powered_up && ana_eff == ANA_RST))
        else $error("power-down did not clear analog settings");
    a_setup_gate: assert property (cmd_valid && cmd_out.kind == CK_ANA
        |-> $past(powered_up) && $past(channel_busy_n) == 4'hf)
        else $error("analog setup accepted while down or playing");
    a_classd_gain: assert property (ana_eff.class_d_select
        |-> ana_eff.dac_path_gain == 2'b00 && ana_eff.ext_input_gain == 2'b00)
        else $error("mixing gains active with class D");
    a_start_busy: assert property (cmd_valid && cmd_out.kind == CK_START
        |-> ##[0:2] (channel_busy_n & cmd_out.channel_mask) == 4'h0)
        else $error("started channel not busy");
    a_stop_quick: assert property (cmd_valid && cmd_out.kind == CK_STOP
        && !ana_eff.soft_stop_enable
        |-> ##[0:2] (channel_busy_n & cmd_out.channel_mask) == cmd_out.channel_mask)
        else $error("hard stop did not release channels");
    a_fade_bound: assert property (cmd_valid && cmd_out.kind == CK_STOP
        |-> ##[0:FADE_MAX] (channel_busy_n & cmd_out.channel_mask) == cmd_out.channel_mask)
        else $error("fade did not end in time");
    a_play_width: assert property (cmd_valid && cmd_out.kind == CK_PLAY
        |-> cmd_out.phrase_number[11:10] == 2'b00)
        else $error("short play carries wide phrase bits");
endmodule

/* verif/spcd_host_model.sv */
`timescale 1ns/1ps
module spcd_host_model (
    // Clock
    input wire logic core_clk,
    // Serial link
    input wire logic cmd_busy_n,
    output logic ser_clk,
    output logic ser_cs_n,
    output logic ser_di
);
    initial begin
        ser_clk = 1'b0;
        ser_cs_n = 1'b1;
        ser_di = 1'b0;
    end

    // No bound here: a stuck busy line is left to the bench watchdog
    task automatic wait_idle();
        while (cmd_busy_n !== 1'b1) begin
            @(posedge core_clk);
        end
    endtask

    // One frame per byte, link clock still outside frames
    task automatic send_byte(input logic [7:0] b);
        wait_idle();
        ser_cs_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            ser_di <= b[i];
            repeat (4) @(posedge core_clk);
            ser_clk <= 1'b1;
            repeat (4) @(posedge core_clk);
            ser_clk <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        ser_cs_n <= 1'b1;
        // Released line must not keep the last bit
        ser_di <= ~b[0];
        repeat (8) @(posedge core_clk);
        wait_idle();
    endtask
endmodule

/* verif/spcd_decoder_tb.sv */
`timescale 1ns/1ps
module spcd_decoder_tb
    import spcd_pkg::*;
;
    localparam int FADE_SIM = 40;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ser_clk, ser_cs_n, ser_di, cmd_busy_n, powered_up, cmd_valid, avs_waitrequest;
    logic [3:0] channel_busy_n;
    spcd_ana_t ana_eff;
    spcd_cmd_t cmd_out, e;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rdat;
    int fails = 0;
    int checked = 0;
    spcd_cmd_t exp_q[$];
    logic [1:0] sel_q[$];
    logic [1:0] s, ci;
    logic dbl = 1'b0;
    logic [3:0] m;
    logic [11:0] ph;
    logic [7:0] b1, b2;
    logic [3:0] nibs [3] = '{NB_START, NB_RSET, NB_RCLR};
    spcd_kind_t kinds [3] = '{CK_START, CK_RSET, CK_RCLR};

    always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

    spcd_decoder #(.FADE_CYCLES(FADE_SIM)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .ser_clk(ser_clk), .ser_cs_n(ser_cs_n), .ser_di(ser_di), .cmd_busy_n(cmd_busy_n),
        .channel_busy_n(channel_busy_n), .powered_up(powered_up), .ana_eff(ana_eff),
        .cmd_out(cmd_out), .cmd_valid(cmd_valid), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    spcd_host_model i_host (.core_clk(core_clk), .cmd_busy_n(cmd_busy_n),
        .ser_clk(ser_clk), .ser_cs_n(ser_cs_n), .ser_di(ser_di));

    // ********************
    // Tasks
    // ********************
    task automatic stop_test();
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n == 100) fails++;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rel(input logic [3:0] mk);
        av(1'b1, REG_CTRL, {28'h0, mk}, rdat);
        repeat (2) @(posedge core_clk);
    endtask

    task automatic ex(input spcd_kind_t k, input logic [3:0] mk, input logic [1:0] ix,
        input logic [11:0] p, input logic [1:0] sl);
        exp_q.push_back({k, mk, ix, p});
        sel_q.push_back(sl);
    endtask

    task automatic tx(input logic [7:0] b);
        i_host.send_byte(b);
        if (dbl) i_host.send_byte(b);
    endtask

    // ********************
    // Result monitor
    // ********************
    always @(posedge core_clk) begin
        if (cmd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("extra command", 32'h1, 32'h0);
            end else begin
                e = exp_q.pop_front();
                s = sel_q.pop_front();
                chk("kind", cmd_out.kind, e.kind);
                if (s[0]) chk("mask", cmd_out.channel_mask, e.channel_mask);
                if (s[1]) chk("index", cmd_out.channel_index, e.channel_index);
                if (s[1]) chk("phrase", cmd_out.phrase_number, e.phrase_number);
            end
        end
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        fails++;
        stop_test();
    end

    // ********************
    // Scenarios
    // ********************
    initial begin
        void'($urandom(13));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        av(1'b0, REG_STATUS, 32'h0, rdat);
        chk("status", rdat, 32'h0000_002f);
        av(1'b0, REG_ANALOG, 32'h0, rdat);
        chk("analog", rdat, 32'h0);
        av(1'b1, 4'h2, 32'hffff_ffff, rdat);
        av(1'b0, 4'h2, 32'h0, rdat);
        chk("unmapped", rdat, 32'h0);
        tx(8'h5f);
        chk("down busy", channel_busy_n, 4'hf);
        ex(CK_PUP, 4'h0, 2'b00, 12'h0, 2'b00);
        tx(8'h00);
        chk("up", powered_up, 1'b1);
        av(1'b0, REG_STATUS, 32'h0, rdat);
        chk("status up", rdat[4], 1'b1);
        m = 4'($urandom_range(15, 1));
        for (int i = 0; i < 3; i++) begin
            ex(kinds[i], m, 2'b00, 12'h0, 2'b01);
            tx({nibs[i], m});
        end
        chk("start busy", channel_busy_n, 4'(~m));
        ex(CK_STOP, 4'hf, 2'b00, 12'h0, 2'b01);
        tx(8'h6f);
        chk("hard stop", channel_busy_n, 4'hf);
        ph = 12'($urandom());
        ci = 2'($urandom());
        ex(CK_PLAY, 4'h0, ci, {2'b00, ph[9:0]}, 2'b10);
        tx({NB_PLAY, ph[9:8], ci});
        tx(ph[7:0]);
        ex(CK_WPLAY, 4'h0, ci, ph, 2'b10);
        tx(OP_WPLAY);
        tx({2'b00, ci, ph[11:8]});
        tx(ph[7:0]);
        ex(CK_WDTCL, 4'h0, 2'b00, 12'h0, 2'b00);
        tx(OP_WDTCL);
        ex(CK_ERRCL, 4'h0, 2'b00, 12'h0, 2'b00);
        tx(OP_ERRCL);
        rel(4'hf);
        ex(CK_START, 4'h1, 2'b00, 12'h0, 2'b01);
        tx(8'h51);
        tx(8'h04);
        tx(8'h85);
        chk("busy setup", ana_eff, ANA_RST);
        rel(4'h1);
        chk("released", channel_busy_n, 4'hf);
        b1 = {6'h01, 1'b0, 1'($urandom())};
        b2 = {1'b1, 2'($urandom_range(2, 1)), 2'($urandom_range(2, 1)), 2'b01, 1'($urandom())};
        ex(CK_ANA, 4'h0, 2'b00, 12'h0, 2'b00);
        tx(b1);
        tx(b2);
        chk("setup", ana_eff, {b2[7:1], 1'b0, b1[1:0]});
        av(1'b0, REG_ANALOG, 32'h0, rdat);
        chk("raw", rdat[9:0], {b2, b1[1:0]});
        ex(CK_START, 4'h3, 2'b00, 12'h0, 2'b01);
        tx(8'h53);
        ex(CK_STOP, 4'h1, 2'b00, 12'h0, 2'b01);
        tx(8'h61);
        chk("fading", channel_busy_n[0], 1'b0);
        repeat (FADE_SIM + 20) @(posedge core_clk);
        chk("faded", channel_busy_n, 4'hd);
        rel(4'h2);
        ex(CK_ANA, 4'h0, 2'b00, 12'h0, 2'b00);
        tx(8'h07);
        tx(8'h22);
        chk("class d", ana_eff, 10'h00b);
        av(1'b0, REG_ANALOG, 32'h0, rdat);
        chk("raw d", rdat[9:0], 10'h08b);
        ex(CK_POWER_DOWN_CMD, 4'h0, 2'b00, 12'h0, 2'b00);
        tx(OP_POWER_DOWN_CMD);
        chk("power_down_cmd", ana_eff, ANA_RST);
        av(1'b0, REG_ANALOG, 32'h0, rdat);
        chk("power_down_cmd raw", rdat, 32'h0);
        ex(CK_PUP, 4'h0, 2'b00, 12'h0, 2'b00);
        tx(8'h01);
        dbl = 1'b1;
        ex(CK_START, 4'h2, 2'b00, 12'h0, 2'b01);
        tx(8'h52);
        // Copies differ, so the second start must be dropped
        i_host.send_byte(8'h51);
        i_host.send_byte(8'h54);
        chk("mismatch", channel_busy_n, 4'hd);
        ex(CK_PLAY, 4'h0, ci, {2'b00, ph[9:0]}, 2'b10);
        tx({NB_PLAY, ph[9:8], ci});
        tx(ph[7:0]);
        chk("pending", 32'(exp_q.size()), 32'h0);
        stop_test();
    end
endmodule

bind spcd_decoder spcd_decoder_chk #(.FADE_CYCLES(FADE_CYCLES)) i_chk (.core_clk(core_clk),
    .rst_n(rst_n), .channel_busy_n(channel_busy_n), .powered_up(powered_up),
    .ana_eff(ana_eff), .cmd_out(cmd_out), .cmd_valid(cmd_valid));
